// ### src/pic_arbiter.sv
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
// Behaviour
// - Each of the 82 sources gets one of three levels (1-3 limited, 0-2 full) except the fixed-level sources.
// - Within one level the smallest active source number wins, 0 first and 81 last.
// - The core is told when a request of sufficient level is pending, with its vector address.
// - A normal vector address is the base register joined with the winning vector number.
// - The core mask bits allow levels 0-3, 1-3, 2-3 or only 3 for codes 00, 01, 10, 11.
// - The current level code is 00 for none, 01 for level 0, 10 for level 1, 11 for 2 or 3.
// - An interrupt is fast only when a match register equals the winner and it is level 2.
// - A fast interrupt presents the matching pair's low and high address instead.
// - The fast address is already presented when the core fetches the vector.
// - Software reaches all registers as a slave on the register bus.
// - A serviceable request during wait or stop asks the system unit to restart clocks.
// - After reset the initial fetch address is driven on the address output.
// - A two-bit field of 00 disables its source, and the reset value is 00.
// - In low power only sources enabled before entry wake, and request A is level sensitive.
module pic_arbiter #(
    parameter logic [pic_pkg::NUM_SRC-1:0] LIMITED_MASK = '1,
    parameter int                          EXT_A_SRC    = 2
) (
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    input  wire logic [7:0]                       avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [31:0]                      avs_writedata,
    output logic [31:0]                           avs_readdata,
    output logic                                  avs_waitrequest,
    input  wire logic [pic_pkg::NUM_SRC-1:0]      irqReq,
    input  wire logic                             extReqA_n,
    input  wire logic [1:0]                       coreMask,
    input  wire logic                             coreAck,
    input  wire logic                             lowPower,
    output pic_pkg::pic_vec_s                     coreVec,
    output logic                                  wakeReq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pic_pkg::pic_state_s s_q;
    pic_pkg::pic_state_s s_d;

    logic [pic_pkg::NUM_SRC-1:0]      reqEff;
    logic [pic_pkg::NUM_SRC-1:0][1:0] srcLvl;
    logic [pic_pkg::NUM_SRC-1:0]      srcOn;
    logic [3:0]                       lvlHit;
    logic [3:0][pic_pkg::VEC_W-1:0]   lvlWin;
    logic [95:0]                      pendBits;
    logic [pic_pkg::IDX_W-1:0]        idx;
    logic                             accept;
    logic                             commit;

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitReq;
    assign coreVec         = s_q.vec;
    assign wakeReq         = s_q.wake;
    assign idx             = avs_address[7:2];

    // Take a request while waitrequest is high, commit it on the edge it rises again
    assign accept = (avs_read | avs_write) & s_q.waitReq;
    assign commit = avs_write & ~s_q.waitReq;

    // ------------------------------------------------------------
    // Source decode and per-level encoders
    // ------------------------------------------------------------
    always_comb begin
        reqEff  = irqReq;
        srcLvl  = '0;
        srcOn   = '0;
        lvlHit  = '0;
        lvlWin  = '0;
        // Edge mode needs a clock to see the edge, so low power falls back to level
        reqEff[EXT_A_SRC] = (s_q.extEdge & ~lowPower) ? s_q.extLatch : ~s_q.extLvl;
        for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
            logic [1:0] code;
            code = 2'h0;
            if (i < pic_pkg::NUM_FIXED) begin
                srcOn[i]  = 1'b1;
                srcLvl[i] = pic_pkg::FIXED_LVL;
            end else begin
                code     = s_q.priority_field_registers[(i - pic_pkg::NUM_FIXED) / 8][((i - pic_pkg::NUM_FIXED) % 8) * 2 +: 2];
                srcOn[i] = (code != 2'h0);
                // Limited fields map to levels 1-3, full fields to levels 0-2
                srcLvl[i] = LIMITED_MASK[i] ? code : code - 2'h1;
            end
        end
        for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (reqEff[i] && srcOn[i]) begin
                lvlHit[srcLvl[i]] = 1'b1;
                lvlWin[srcLvl[i]] = 7'(i);
            end
        end
    end

    always_comb begin
        pendBits = '0;
        pendBits[pic_pkg::NUM_SRC-1:0] = reqEff & srcOn;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0]              winLvl;
        logic                    anyWin;
        logic [pic_pkg::VEC_W-1:0] winNum;
        logic                    m0;
        logic                    m1;
        logic [31:0]             rd;
        s_d    = s_q;
        winLvl = 2'h0;
        anyWin = 1'b0;
        winNum = '0;
        rd     = '0;

        // External request A synchroniser, change taken once the last two agree
        s_d.extSync = {s_q.extSync[1:0], extReqA_n};
        if (s_q.extSync[1] == s_q.extSync[2]) begin
            s_d.extLvl = s_q.extSync[2];
        end
        // Falling edge sets the latch; the set wins over the core's acknowledge
        if (coreAck && s_q.vec.pending && s_q.vec.vecNum == 7'(EXT_A_SRC)) begin
            s_d.extLatch = 1'b0;
        end
        if (s_q.extLvl && (s_q.extSync[1] == s_q.extSync[2]) && !s_q.extSync[2]) begin
            s_d.extLatch = 1'b1;
        end

        // Highest permitted level first, lowest number within it
        for (int l = 0; l < 4; l++) begin
            if (lvlHit[l] && 2'(l) >= coreMask) begin
                winLvl = 2'(l);
                anyWin = 1'b1;
                winNum = lvlWin[l];
            end
        end
        m0 = (winNum == s_q.fim[0]);
        m1 = (winNum == s_q.fim[1]);

        s_d.lvl              = winLvl;
        s_d.vec.pending      = anyWin;
        s_d.vec.vecNum       = winNum;
        s_d.vec.fast         = anyWin && (winLvl == pic_pkg::FAST_LVL) && (m0 || m1);
        s_d.vec.levelCode    = !anyWin ? pic_pkg::CODE_NONE : (winLvl >= 2'h2) ? 2'h3 :
                               winLvl + 2'h1;
        if (s_d.vec.fast) begin
            // Match register 0 has precedence when both hold the same number
            s_d.vec.addr = m0 ? {s_q.fivah[0], s_q.fival[0]} : {s_q.fivah[1], s_q.fival[1]};
        end else begin
            // With nothing pending this is the reset fetch address
            s_d.vec.addr = {s_q.vector_base_register, winNum};
        end

        // Low power wake: only sources enabled on entry may wake
        s_d.lowPwrDly = lowPower;
        if (lowPower && !s_q.lowPwrDly) begin
            s_d.wakeMask = srcOn;
        end
        s_d.wake = lowPower && s_q.lowPwrDly && |(reqEff & s_q.wakeMask);

        // Register bus slave
        s_d.waitReq = ~accept;
        if (accept && avs_read) begin
            if (idx < pic_pkg::IDX_VBA) begin
                rd[15:0] = s_q.priority_field_registers[idx[3:0]];
            end else if (idx >= pic_pkg::IDX_IRQP0 && idx < pic_pkg::IDX_IRQP0 + 6'(pic_pkg::NUM_PEND)) begin
                rd[15:0] = pendBits[(idx - pic_pkg::IDX_IRQP0) * 16 +: 16];
            end else begin
                unique case (idx)
                    pic_pkg::IDX_VBA:    rd[pic_pkg::VBA_W-1:0] = s_q.vector_base_register;
                    pic_pkg::IDX_FAST_MATCH_REG_0:   rd[pic_pkg::VEC_W-1:0] = s_q.fim[0];
                    pic_pkg::IDX_FIVAL0: rd[15:0] = s_q.fival[0];
                    pic_pkg::IDX_FIVAH0: rd[pic_pkg::FAH_W-1:0] = s_q.fivah[0];
                    pic_pkg::IDX_FAST_MATCH_REG_1:   rd[pic_pkg::VEC_W-1:0] = s_q.fim[1];
                    pic_pkg::IDX_FIVAL1: rd[15:0] = s_q.fival[1];
                    pic_pkg::IDX_FIVAH1: rd[pic_pkg::FAH_W-1:0] = s_q.fivah[1];
                    pic_pkg::IDX_ICTL: begin
                        rd[pic_pkg::ICTL_EDGE_BIT]           = s_q.extEdge;
                        rd[pic_pkg::ICTL_LVL_LSB +: 2]       = s_q.vec.levelCode;
                        rd[pic_pkg::ICTL_PEND_BIT]           = s_q.vec.pending;
                        rd[pic_pkg::ICTL_FAST_BIT]           = s_q.vec.fast;
                    end
                    default:             rd = '0;
                endcase
            end
            s_d.rdata = rd;
        end
        if (commit) begin
            if (idx < pic_pkg::IDX_VBA) begin
                s_d.priority_field_registers[idx[3:0]] = avs_writedata[15:0];
            end else begin
                unique case (idx)
                    pic_pkg::IDX_VBA:    s_d.vector_base_register      = avs_writedata[pic_pkg::VBA_W-1:0];
                    pic_pkg::IDX_FAST_MATCH_REG_0:   s_d.fim[0]   = avs_writedata[pic_pkg::VEC_W-1:0];
                    pic_pkg::IDX_FIVAL0: s_d.fival[0] = avs_writedata[15:0];
                    pic_pkg::IDX_FIVAH0: s_d.fivah[0] = avs_writedata[pic_pkg::FAH_W-1:0];
                    pic_pkg::IDX_FAST_MATCH_REG_1:   s_d.fim[1]   = avs_writedata[pic_pkg::VEC_W-1:0];
                    pic_pkg::IDX_FIVAL1: s_d.fival[1] = avs_writedata[15:0];
                    pic_pkg::IDX_FIVAH1: s_d.fivah[1] = avs_writedata[pic_pkg::FAH_W-1:0];
                    pic_pkg::IDX_ICTL:   s_d.extEdge  = avs_writedata[pic_pkg::ICTL_EDGE_BIT];
                    default:             s_d.extEdge  = s_q.extEdge;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.vector_base_register      <= pic_pkg::VBA_RST;
            s_q.extSync  <= 3'h7;
            s_q.extLvl   <= 1'b1;
            s_q.waitReq  <= 1'b1;
            s_q.vec.addr <= {pic_pkg::VBA_RST, 7'h00};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Match and address registers may be rewritten while a vector stands, so compare
    // against the values the vector was built from one edge earlier
    fast_match_a: assert property (coreVec.fast |-> (s_q.lvl == 2'h2) &&
        (coreVec.vecNum == $past(s_q.fim[0]) || coreVec.vecNum == $past(s_q.fim[1])))
        else $error("fast flag without level 2 match");
    mask_gate_a: assert property (##1 coreVec.pending |-> s_q.lvl >= $past(coreMask))
        else $error("masked level presented");
    level_code_a: assert property (coreVec.pending |-> coreVec.levelCode ==
        ((s_q.lvl >= 2'h2) ? 2'h3 : s_q.lvl + 2'h1))
        else $error("level code mismatch");
    normal_addr_a: assert property (coreVec.pending && !coreVec.fast |->
        coreVec.addr == {$past(s_q.vector_base_register), coreVec.vecNum})
        else $error("normal vector address wrong");
    fast_addr_a: assert property (coreVec.fast |->
        coreVec.addr == {$past(s_q.fivah[0]), $past(s_q.fival[0])} ||
        coreVec.addr == {$past(s_q.fivah[1]), $past(s_q.fival[1])})
        else $error("fast vector address wrong");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle later");
    wake_gate_a: assert property (wakeReq |-> $past(lowPower) && $past(lowPower, 2))
        else $error("wake outside low power");
    reset_fetch_a: assert property (!coreVec.pending |->
        coreVec.addr == {$past(s_q.vector_base_register), 7'h00})
        else $error("idle address not reset fetch");

    // ------------------------------------------------------------
    // Vector, bus and wake checks
    // ------------------------------------------------------------
    idle_level_a: assert property (!coreVec.pending |->
        coreVec.levelCode == pic_pkg::CODE_NONE && !coreVec.fast)
        else $error("idle vector not cleared");

    pend_source_a: assert property (coreVec.pending |-> $past(|(reqEff & srcOn)))
        else $error("pending without enabled request");

    hit_taken_a: assert property ((|lvlHit) && coreMask == 2'h0 |=> coreVec.pending)
        else $error("unmasked request not presented");

    pend_clear_a: assert property (!(|lvlHit) |=> !coreVec.pending)
        else $error("pending without level hit");

    wake_off_a: assert property (!lowPower |=> !wakeReq)
        else $error("wake outside low power");

    reserved_zero_a: assert property (avs_read && avs_waitrequest &&
        avs_address[7:2] == 6'h1c |=> avs_readdata == 32'h0)
        else $error("unmapped register not zero");

    fixed_level_a: assert property (coreVec.pending &&
        coreVec.vecNum < 7'(pic_pkg::NUM_FIXED) |-> coreVec.levelCode == 2'h3)
        else $error("fixed source not at top level");

    fast_code_a: assert property (coreVec.fast |->
        coreVec.pending && coreVec.levelCode == 2'h3)
        else $error("fast vector with wrong level code");

    top_mask_a: assert property (##1 coreVec.pending && $past(coreMask) == 2'h3 |->
        coreVec.levelCode == 2'h3)
        else $error("level below 3 under full mask");

    mask_one_a: assert property (##1 coreVec.pending && $past(coreMask) == 2'h1 |->
        coreVec.levelCode != 2'h1)
        else $error("level 0 under mask 01");

    fast_pair0_a: assert property (coreVec.fast && $past(s_q.fim[0]) == coreVec.vecNum |->
        coreVec.addr == {$past(s_q.fivah[0]), $past(s_q.fival[0])})
        else $error("pair 0 address not used");

    fast_pair1_a: assert property (coreVec.fast && $past(s_q.fim[0]) != coreVec.vecNum |->
        coreVec.addr == {$past(s_q.fivah[1]), $past(s_q.fival[1])})
        else $error("pair 1 address not used");

    bus_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=>
        avs_waitrequest)
        else $error("answer without request");

    answer_drop_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");

    rdata_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved without answer");

    vec_range_a: assert property (coreVec.pending |->
        coreVec.vecNum < 7'(pic_pkg::NUM_SRC))
        else $error("vector number out of range");

    zero_wins_a: assert property ($past(irqReq[0]) && !$past(sys_rst) |->
        coreVec.pending && coreVec.vecNum == 7'h0)
        else $error("source 0 not first");

    level_one_a: assert property (coreVec.pending && s_q.lvl == 2'h0 |->
        coreVec.levelCode == 2'h1)
        else $error("level 0 code wrong");

    fast_seen_c:   cover property (coreVec.fast);
    edge_latch_c:  cover property (s_q.extEdge && s_q.extLatch);
    nested_c:      cover property (coreVec.pending && coreMask == 2'h3);
    wake_seen_c:   cover property (wakeReq);
    bus_write_c:   cover property (avs_write && !avs_waitrequest);

endmodule : pic_arbiter

// ### src/pic_pkg.sv
package pic_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC   = 82;
    localparam int NUM_FIXED = 2;
    localparam int NUM_IPR   = 10;
    localparam int NUM_PEND  = 6;
    localparam int VEC_W     = 7;
    localparam int VBA_W     = 14;
    localparam int FAH_W     = 5;
    localparam int ADDR_W    = 21;
    localparam int IDX_W     = 6;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_IPR0   = 6'h00;
    localparam logic [IDX_W-1:0] IDX_VBA    = 6'h0a;
    localparam logic [IDX_W-1:0] IDX_FAST_MATCH_REG_0   = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_FIVAL0 = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_FIVAH0 = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_FAST_MATCH_REG_1   = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_FIVAL1 = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_FIVAH1 = 6'h10;
    localparam logic [IDX_W-1:0] IDX_IRQP0  = 6'h11;
    localparam logic [IDX_W-1:0] IDX_ICTL   = 6'h1d;

    // ------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------
    localparam int ICTL_EDGE_BIT    = 0;
    localparam int ICTL_LVL_LSB     = 2;
    localparam int ICTL_PEND_BIT    = 4;
    localparam int ICTL_FAST_BIT    = 5;
    localparam logic [VBA_W-1:0] VBA_RST = 14'h0000;
    localparam logic [1:0] FIXED_LVL     = 2'h3;
    localparam logic [1:0] FAST_LVL      = 2'h2;
    localparam logic [1:0] CODE_NONE     = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              pending;
        logic              fast;
        logic [1:0]        levelCode;
        logic [VEC_W-1:0]  vecNum;
        logic [ADDR_W-1:0] addr;
    } pic_vec_s;

    typedef struct packed {
        logic [NUM_IPR-1:0][15:0] priority_field_registers;
        logic [VBA_W-1:0]         vector_base_register;
        logic [1:0][VEC_W-1:0]    fim;
        logic [1:0][15:0]         fival;
        logic [1:0][FAH_W-1:0]    fivah;
        logic                     extEdge;
        logic [2:0]               extSync;
        logic                     extLvl;
        logic                     extLatch;
        logic                     lowPwrDly;
        logic [NUM_SRC-1:0]       wakeMask;
        logic                     wake;
        logic [1:0]               lvl;
        logic                     waitReq;
        logic [31:0]              rdata;
        pic_vec_s                 vec;
    } pic_state_s;

endpackage : pic_pkg

// ### testbench/pic_core_model.sv
`timescale 1ns/100ps
// --------------------------------------------------------
// Core side: accepts each newly presented vector
// --------------------------------------------------------
module pic_core_model (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire pic_pkg::pic_vec_s coreVec,
    output logic                   coreAck,
    output logic                   fastMode
);
    pic_pkg::pic_vec_s lastVec;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            coreAck  <= 1'b0;
            lastVec  <= '0;
            fastMode <= 1'b0;
        end else begin
            // One pulse per newly presented vector, so a held one is not taken twice
            coreAck <= coreVec.pending && (coreVec != lastVec);
            lastVec <= coreVec;
            if (coreAck) begin
                fastMode <= coreVec.fast;
            end
        end
    end
endmodule : pic_core_model

// ### testbench/pic_arbiter_bench.sv
`timescale 1ns/100ps
module pic_arbiter_bench;
    logic                        clk;
    logic                        sysRst;
    logic [7:0]                  avsAddress;
    logic                        avsRead;
    logic                        avsWrite;
    logic [31:0]                 avsWritedata;
    logic [31:0]                 avsReaddata;
    logic                        avsWaitrequest;
    logic [pic_pkg::NUM_SRC-1:0] irqReq;
    logic                        extReqA_n;
    logic [1:0]                  coreMask;
    logic                        coreAck;
    logic                        lowPower;
    logic                        fastMode;
    logic                        wakeReq;
    pic_pkg::pic_vec_s           coreVec;
    logic [31:0]                 rd;
    logic [13:0]                 vector_base_register;
    int                          badCount;
    int                          numChecks;

    pic_arbiter uut (.clk(clk), .sys_rst(sysRst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .irqReq(irqReq),
        .extReqA_n(extReqA_n), .coreMask(coreMask), .coreAck(coreAck),
        .lowPower(lowPower), .coreVec(coreVec), .wakeReq(wakeReq));

    pic_core_model core (.clk(clk), .sys_rst(sysRst), .coreVec(coreVec),
        .coreAck(coreAck), .fastMode(fastMode));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // --------------------------------------------------------
    // Checking and bus tasks
    // --------------------------------------------------------
    task automatic completeRun();
        $display("Mismatches %0d, checks %0d", badCount, numChecks);
        if (badCount == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : completeRun

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkWord

    task automatic chkVec(input pic_pkg::pic_vec_s exp);
        numChecks++;
        if (coreVec !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, coreVec, exp);
        end
    endtask : chkVec

    // Request held until waitrequest is seen low; released after that edge
    task automatic busCycle(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress   <= {idx, 2'b00};
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        @(posedge clk);
        while (avsWaitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) badCount++;
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge clk);
    endtask : busCycle

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        busCycle(1'b1, idx, d);
    endtask : wr

    task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
        busCycle(1'b0, idx, 32'h0);
        chkWord(rd, exp);
    endtask : rdChk

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle

    function automatic pic_pkg::pic_vec_s mk(input logic f, input logic [1:0] lc,
                                             input logic [6:0] vn, input logic [20:0] a);
        mk = {1'b1, f, lc, vn, a};
    endfunction : mk

    // --------------------------------------------------------
    // Tests
    // --------------------------------------------------------
    initial begin
        sysRst = 1'b1;
        avsAddress = 8'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        irqReq = '0;
        extReqA_n = 1'b1;
        coreMask = 2'h0;
        lowPower = 1'b0;
        badCount = 0;
        numChecks = 0;
        vector_base_register = 14'h2a5;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        chkVec('0);
        chkWord({31'h0, wakeReq}, 32'h0);
        rdChk(pic_pkg::IDX_IPR0, 32'h0);
        rdChk(pic_pkg::IDX_FAST_MATCH_REG_0, 32'h0);
        wr(pic_pkg::IDX_VBA, {18'h0, vector_base_register});
        rdChk(pic_pkg::IDX_VBA, {18'h0, vector_base_register});
        wr(6'h1c, 32'hffff);
        rdChk(6'h1c, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wr(6'(i), 32'h5555);
        end
        rdChk(6'h03, 32'h5555);
        irqReq[81] <= 1'b1;
        irqReq[9] <= 1'b1;
        settle();
        chkVec(mk(1'b0, 2'h2, 7'd9, {vector_base_register, 7'd9}));
        irqReq[9] <= 1'b0;
        settle();
        chkVec(mk(1'b0, 2'h2, 7'd81, {vector_base_register, 7'd81}));
        irqReq[0] <= 1'b1;
        settle();
        chkVec(mk(1'b0, 2'h3, 7'd0, {vector_base_register, 7'd0}));
        irqReq[0] <= 1'b0;
        wr(6'h09, 32'hd555);
        irqReq[9] <= 1'b1;
        settle();
        chkVec(mk(1'b0, 2'h3, 7'd81, {vector_base_register, 7'd81}));
        irqReq[81] <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            coreMask <= 2'(m);
            settle();
            chkWord({31'h0, coreVec.pending}, {31'h0, m <= 1});
        end
        irqReq[81] <= 1'b1;
        settle();
        chkVec(mk(1'b0, 2'h3, 7'd81, {vector_base_register, 7'd81}));
        irqReq[81] <= 1'b0;
        coreMask <= 2'h0;
        wr(pic_pkg::IDX_IPR0, 32'h9555);
        wr(pic_pkg::IDX_FAST_MATCH_REG_1, 32'h9);
        wr(pic_pkg::IDX_FIVAL1, 32'h1234);
        wr(pic_pkg::IDX_FIVAH1, 32'h0a);
        rdChk(pic_pkg::IDX_FIVAH1, 32'h0a);
        chkVec(mk(1'b1, 2'h3, 7'd9, {5'h0a, 16'h1234}));
        chkWord({31'h0, fastMode}, 32'h1);
        wr(pic_pkg::IDX_IPR0, 32'hd555);
        settle();
        chkVec(mk(1'b0, 2'h3, 7'd9, {vector_base_register, 7'd9}));
        irqReq[9] <= 1'b0;
        wr(pic_pkg::IDX_IPR0, 32'hd515);
        lowPower <= 1'b1;
        settle();
        irqReq[5] <= 1'b1;
        settle();
        chkWord({31'h0, wakeReq}, 32'h0);
        irqReq[9] <= 1'b1;
        settle();
        chkWord({31'h0, wakeReq}, 32'h1);
        irqReq <= '0;
        lowPower <= 1'b0;
        settle();
        extReqA_n <= 1'b0;
        repeat (8) @(posedge clk);
        chkVec(mk(1'b0, 2'h2, 7'd2, {vector_base_register, 7'd2}));
        extReqA_n <= 1'b1;
        settle();
        wr(pic_pkg::IDX_ICTL, 32'h1);
        rdChk(pic_pkg::IDX_ICTL, 32'h1);
        extReqA_n <= 1'b0;
        repeat (10) @(posedge clk);
        chkVec({1'b0, 1'b0, 2'h0, 7'h0, vector_base_register, 7'h0});
        extReqA_n <= 1'b1;
        completeRun();
    end

    // Run needs well under a thousand cycles
    initial begin
        #2000000;
        badCount++;
        completeRun();
    end
endmodule : pic_arbiter_bench
